// ===== design/cdr_rate_pkg.sv
// Notes on behaviour
// - Manual field codes bypass, MADI, SD, HD, 3G.
// - Recovery follows manual rate only when auto off.
// - Bit zero enables auto detection, resets to one.
// - Bit four picks SD/MADI boundary 181 or 198.
// - Bits three to zero select low MADI boundary.
package cdr_rate_pkg;

  localparam int REG_AW = 8;
  localparam int REG_DW = 16;
  localparam int RATE_W = 12;

  localparam logic [7:0] RATE_MODE_OFFSET = 8'h06;
  localparam logic [7:0] RATE_CFG_OFFSET = 8'h07;
  localparam logic [7:0] RESERVED_EIGHT_OFFSET = 8'h08;

  // Field positions in the rate mode select register.
  localparam int AUTO_ENABLE_BIT = 0;
  localparam int MANUAL_RATE_LSB = 1;
  localparam int MANUAL_RATE_MSB = 4;
  localparam int MODE_RESERVED_EIGHT_LSB = 5;

  // Field positions in the rate threshold config register.
  localparam int LOW_LOWER_LSB = 0;
  localparam int LOW_UPPER_MSB = 3;
  localparam int SD_MADI_BIT = 4;

  // Reset values; the reserved mode field holds 1F0 in bits 15:5.
  localparam logic [15:0] RATE_MODE_RESET = 16'h3E01;
  localparam logic [15:0] RATE_CFG_RESET = 16'h0003;
  localparam logic [15:0] RESERVED_EIGHT_RESET = 16'h0003;

  // Rate codes as carried by the manual field and the rate output.
  localparam logic [3:0] RATE_BYPASS = 4'h0;
  localparam logic [3:0] RATE_MADI = 4'h1;
  localparam logic [3:0] RATE_SD = 4'h2;
  localparam logic [3:0] RATE_HD = 4'h3;
  localparam logic [3:0] RATE_3G = 4'h4;

  // Boundaries in Mb/s.
  localparam logic [11:0] SD_MADI_LOW_MBPS = 12'h0B5;
  localparam logic [11:0] SD_MADI_HIGH_MBPS = 12'h0C6;
  localparam logic [11:0] SD_HD_MBPS_DEF = 12'h384;
  localparam logic [11:0] HD_3G_MBPS_DEF = 12'h8CA;

  // Low boundary selector to threshold in Mb/s.
  function automatic logic [11:0] low_boundary_mbps(
    input logic [3:0] code
  );
    logic [11:0] mbps;
    mbps = 12'h06F;
    unique case (code)
      4'h0: mbps = 12'h035;
      4'h1, 4'h2: mbps = 12'h020;
      4'h3: mbps = 12'h04F;
      4'h4, 4'h5, 4'h6: mbps = 12'h03F;
      4'h7, 4'h8, 4'h9: mbps = 12'h030;
      4'hA: mbps = 12'h05F;
      default: mbps = 12'h06F;
    endcase
    return mbps;
  endfunction

  function automatic logic manual_code_legal(input logic [3:0] code);
    return code <= RATE_3G;
  endfunction

endpackage

// ===== design/rate_classifier.sv
`timescale 1ns/100ps
`default_nettype none
module rate_classifier
  import cdr_rate_pkg::*;
#(
  parameter logic [11:0] SD_HD_MBPS = SD_HD_MBPS_DEF,
  parameter logic [11:0] HD_3G_MBPS = HD_3G_MBPS_DEF
) (
  input wire logic [RATE_W-1:0] measured_rate_in,
  input wire logic [11:0] sd_madi_mbps_in,
  input wire logic [11:0] low_mbps_in,
  output logic [3:0] rate_code_out
);

  // Checked from the top rate down so overlapping settings still resolve.
  wire above_3g = measured_rate_in >= HD_3G_MBPS;
  wire above_hd = measured_rate_in >= SD_HD_MBPS;
  wire above_sd = measured_rate_in >= sd_madi_mbps_in;
  wire above_madi = measured_rate_in >= low_mbps_in;

  assign rate_code_out = above_3g ? RATE_3G :
                         above_hd ? RATE_HD :
                         above_sd ? RATE_SD :
                         above_madi ? RATE_MADI : RATE_BYPASS;

endmodule
`default_nettype wire

// ===== design/cdr_rate_detect_config.sv
`timescale 1ns/100ps
`default_nettype none
module cdr_rate_detect_config
  import cdr_rate_pkg::*;
#(
  parameter logic [11:0] SD_HD_MBPS = SD_HD_MBPS_DEF,
  parameter logic [11:0] HD_3G_MBPS = HD_3G_MBPS_DEF
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic soft_reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [REG_AW-1:0] reg_addr_in,
  input wire logic [REG_DW-1:0] reg_wdata_in,
  output logic [REG_DW-1:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic [RATE_W-1:0] measured_rate_in,
  input wire logic measured_valid_in,
  output logic [3:0] cdr_rate_out,
  output logic cdr_bypass_out,
  output logic auto_rate_enable_out,
  output logic [11:0] sd_madi_mbps_out,
  output logic [11:0] low_mbps_out
);

  generate
    if (SD_HD_MBPS <= SD_MADI_HIGH_MBPS || HD_3G_MBPS <= SD_HD_MBPS) begin
      $error("Rate boundaries must rise from SD/HD to HD/3G.");
    end
  endgenerate

  logic [15:0] rate_mode_select;
  logic [15:0] rate_threshold_config;
  logic [15:0] reserved_eight;
  logic [3:0] cdr_rate;
  logic [15:0] rdata;
  logic ack;

  wire sel_mode = reg_addr_in == RATE_MODE_OFFSET;
  wire sel_cfg = reg_addr_in == RATE_CFG_OFFSET;
  wire sel_reserved_eight = reg_addr_in == RESERVED_EIGHT_OFFSET;
  wire wr_mode = ce_in && reg_wr_in && sel_mode;
  wire wr_cfg = ce_in && reg_wr_in && sel_cfg;
  wire wr_reserved_eight = ce_in && reg_wr_in && sel_reserved_eight;

  wire auto_rate_enable = rate_mode_select[AUTO_ENABLE_BIT];
  wire [3:0] manual_rate =
    rate_mode_select[MANUAL_RATE_MSB:MANUAL_RATE_LSB];
  wire sd_vs_madi_boundary = rate_threshold_config[SD_MADI_BIT];
  // Upper and lower bit pairs act as one selector, never separately.
  wire [3:0] low_code =
    rate_threshold_config[LOW_UPPER_MSB:LOW_LOWER_LSB];
  wire [1:0] low_boundary_upper_bits = low_code[3:2];
  wire [1:0] low_boundary_lower_bits = low_code[1:0];

  wire [11:0] sd_madi_mbps = sd_vs_madi_boundary ?
    SD_MADI_HIGH_MBPS : SD_MADI_LOW_MBPS;
  wire [11:0] low_mbps =
    low_boundary_mbps({low_boundary_upper_bits,
                       low_boundary_lower_bits});

  wire [3:0] detected_rate;

  rate_classifier #(
    .SD_HD_MBPS(SD_HD_MBPS),
    .HD_3G_MBPS(HD_3G_MBPS)
  ) u_classifier (
    .measured_rate_in(measured_rate_in),
    .sd_madi_mbps_in(sd_madi_mbps),
    .low_mbps_in(low_mbps),
    .rate_code_out(detected_rate)
  );

  // Reserved manual codes park the loop in bypass rather than guessing.
  wire [3:0] manual_target = manual_code_legal(manual_rate) ?
    manual_rate : RATE_BYPASS;
  wire take_manual = !auto_rate_enable;
  wire take_auto = auto_rate_enable && measured_valid_in;
  wire [3:0] next_cdr_rate = take_manual ? manual_target :
                             take_auto ? detected_rate : cdr_rate;

  wire [15:0] next_rdata = sel_mode ? rate_mode_select :
                           sel_cfg ? rate_threshold_config :
                           sel_reserved_eight ? reserved_eight : 16'h0000;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rate_mode_select <= RATE_MODE_RESET;
      rate_threshold_config <= RATE_CFG_RESET;
      reserved_eight <= RESERVED_EIGHT_RESET;
    end else if (ce_in && soft_reset_in) begin
      rate_mode_select <= RATE_MODE_RESET;
      rate_threshold_config <= RATE_CFG_RESET;
      reserved_eight <= RESERVED_EIGHT_RESET;
    end else begin
      if (wr_mode) begin
        rate_mode_select <= reg_wdata_in;
      end
      if (wr_cfg) begin
        rate_threshold_config <= reg_wdata_in;
      end
      if (wr_reserved_eight) begin
        reserved_eight <= reg_wdata_in;
      end
    end
  end

  // A soft reset leaves the rate as it is; it holds until the restored auto mode sees a valid measurement.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cdr_rate <= RATE_BYPASS;
    end else if (ce_in) begin
      cdr_rate <= next_cdr_rate;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata <= 16'h0000;
      ack <= 1'b0;
    end else if (ce_in) begin
      ack <= reg_rd_in || reg_wr_in;
      if (reg_rd_in) begin
        rdata <= next_rdata;
      end
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_ack_out = ack;
  assign cdr_rate_out = cdr_rate;
  assign cdr_bypass_out = cdr_rate == RATE_BYPASS;
  assign auto_rate_enable_out = auto_rate_enable;
  assign sd_madi_mbps_out = sd_madi_mbps;
  assign low_mbps_out = low_mbps;

  sequence write_manual_s;
    wr_mode && !reg_wdata_in[AUTO_ENABLE_BIT] && !soft_reset_in;
  endsequence

  manual_rate_only_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && !auto_rate_enable |=> cdr_rate == $past(manual_target)
  ) else $error("Manual mode rate does not follow the manual field.");

  manual_code_map_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && !auto_rate_enable && !manual_code_legal(manual_rate)
    |=> cdr_rate == RATE_BYPASS && cdr_bypass_out
  ) else $error("Reserved manual code did not park in bypass.");

  write_then_manual_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    write_manual_s |=> !auto_rate_enable_out &&
    rate_mode_select == $past(reg_wdata_in)
  ) else $error("Clearing the enable bit did not leave auto mode.");

  auto_reset_value_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && soft_reset_in |=> auto_rate_enable_out &&
    rate_mode_select == RATE_MODE_RESET
  ) else $error("Soft reset did not restore automatic mode.");

  sd_boundary_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    wr_cfg && !soft_reset_in |=> sd_madi_mbps_out ==
    ($past(reg_wdata_in[SD_MADI_BIT]) ? 12'h0C6 : 12'h0B5)
  ) else $error("SD/MADI boundary does not match bit four.");

  low_boundary_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    wr_cfg && !soft_reset_in && reg_wdata_in[3:0] == 4'h3
    |=> low_mbps_out == 12'h04F
  ) else $error("Low boundary selector 3 is not 79 Mb/s.");

  auto_classify_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && take_auto && measured_rate_in < low_mbps
    |=> cdr_bypass_out
  ) else $error("Rate below the low boundary did not bypass.");

  auto_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    auto_rate_enable && !measured_valid_in |=> $stable(cdr_rate)
  ) else $error("Auto rate moved without a valid measurement.");

  manual_sequence_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    write_manual_s ##1 (ce_in && !soft_reset_in && !wr_mode)
    |=> cdr_rate == $past(manual_target)
  ) else $error("Manual rate not applied after leaving auto mode.");

  read_answer_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && reg_rd_in |=> reg_ack_out && reg_rdata_out == $past(next_rdata)
  ) else $error("Register read answer wrong or late.");

  // A frozen cycle must not move anything software or the loop can see.
  freeze_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    !ce_in |=> $stable(cdr_rate) && $stable(rate_mode_select) &&
    $stable(rate_threshold_config) && $stable(reg_ack_out)
  ) else $error("State moved while the clock enable was low.");

  ack_pulse_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && (reg_rd_in || reg_wr_in) |=> reg_ack_out
  ) else $error("Accepted register access was not acknowledged.");

  ack_idle_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    ce_in && !reg_rd_in && !reg_wr_in |=> !reg_ack_out
  ) else $error("Acknowledge raised without a register access.");

  cfg_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    wr_cfg && !soft_reset_in |=>
    rate_threshold_config == $past(reg_wdata_in) &&
    sd_vs_madi_boundary == $past(reg_wdata_in[SD_MADI_BIT])
  ) else $error("Threshold config write did not land.");

endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  num_errors++; $display("CHECK FAILED at %0t ns: got %0h expected %0h", \
  $time, (a), (b)); end end
module testbench;
  import cdr_rate_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [REG_AW-1:0] reg_addr_in = 8'h00;
  logic [REG_DW-1:0] reg_wdata_in = 16'h0000;
  logic [RATE_W-1:0] measured_rate_in = 12'h000;
  logic measured_valid_in = 1'b0;
  logic [REG_DW-1:0] reg_rdata_out;
  logic reg_ack_out;
  logic [3:0] cdr_rate_out;
  logic cdr_bypass_out;
  logic auto_rate_enable_out;
  logic [11:0] sd_madi_mbps_out;
  logic [11:0] low_mbps_out;
  int num_errors = 0;
  int check_count = 0;
  logic [11:0] bnd [4];
  logic [4:0] cfg;
  logic [3:0] last;

  cdr_rate_detect_config i_cdr_rate_detect_config (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .ce_in(ce_in), .soft_reset_in(soft_reset_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_ack_out(reg_ack_out), .measured_rate_in(measured_rate_in),
    .measured_valid_in(measured_valid_in), .cdr_rate_out(cdr_rate_out),
    .cdr_bypass_out(cdr_bypass_out),
    .auto_rate_enable_out(auto_rate_enable_out),
    .sd_madi_mbps_out(sd_madi_mbps_out), .low_mbps_out(low_mbps_out));

  always #50 clk_sys_in = ~clk_sys_in;

  function automatic logic [11:0] exp_low(input logic [3:0] c);
    case (c)
      4'h0: return 12'h035;
      4'h1, 4'h2: return 12'h020;
      4'h3: return 12'h04F;
      4'h4, 4'h5, 4'h6: return 12'h03F;
      4'h7, 4'h8, 4'h9: return 12'h030;
      4'hA: return 12'h05F;
      default: return 12'h06F;
    endcase
  endfunction

  function automatic logic [3:0] exp_class(input logic [11:0] r,
                                           input logic [4:0] c);
    if (r >= 12'h8CA) return 4'h4;
    if (r >= 12'h384) return 4'h3;
    if (r >= (c[4] ? 12'h0C6 : 12'h0B5)) return 4'h2;
    if (r >= exp_low(c[3:0])) return 4'h1;
    return 4'h0;
  endfunction

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
    `CHK(reg_ack_out, 1'b1)
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_sys_in);
    reg_rd_in = 1'b0;
    `CHK(reg_ack_out, 1'b1)
    `CHK(reg_rdata_out, d)
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The full run needs well under 3000 cycles; this leaves a wide margin.
  initial begin
    #(100 * 20000);
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h37d22791));
    repeat (20) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    `CHK(auto_rate_enable_out, 1'b1)
    `CHK(sd_madi_mbps_out, 12'h0B5)
    `CHK(low_mbps_out, 12'h04F)
    `CHK(cdr_bypass_out, 1'b1)
    reg_read(8'h06, 16'h3E01);
    reg_read(8'h07, 16'h0003);
    reg_read(8'h08, 16'h0003);
    reg_read(8'h09, 16'h0000);
    $display("reset values test done");
    // Live measurements keep arriving so that manual mode must ignore them.
    measured_valid_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      measured_rate_in = 12'($urandom);
      reg_write(8'h06, {11'h1F0, 4'(i), 1'b0});
      @(negedge clk_sys_in);
      `CHK(cdr_rate_out, (i <= 4) ? 4'(i) : 4'h0)
      `CHK(cdr_bypass_out, (i == 0 || i > 4))
      `CHK(auto_rate_enable_out, 1'b0)
    end
    $display("manual rate test done");
    for (int i = 0; i < 32; i++) begin
      if (i[3:0] <= 4'hC) begin
        reg_write(8'h07, 16'(i));
        `CHK(sd_madi_mbps_out, i[4] ? 12'h0C6 : 12'h0B5)
        `CHK(low_mbps_out, exp_low(i[3:0]))
      end
    end
    reg_read(8'h07, 16'h001C);
    $display("threshold test done");
    reg_write(8'h06, 16'h3E01);
    for (int t = 0; t < 6; t++) begin
      cfg = {1'($urandom), 4'($urandom_range(12))};
      reg_write(8'h07, 16'(cfg));
      bnd = '{12'h8CA, 12'h384, cfg[4] ? 12'h0C6 : 12'h0B5,
              exp_low(cfg[3:0])};
      for (int k = 0; k < 24; k++) begin
        @(negedge clk_sys_in);
        measured_valid_in = 1'b1;
        measured_rate_in = (k < 8) ? bnd[k % 4] - 12'(k / 4)
                                   : 12'($urandom);
        @(negedge clk_sys_in);
        `CHK(cdr_rate_out, exp_class(measured_rate_in, cfg))
        last = exp_class(measured_rate_in, cfg);
        measured_valid_in = 1'b0;
        measured_rate_in = 12'($urandom);
        @(negedge clk_sys_in);
        `CHK(cdr_rate_out, last)
      end
    end
    $display("automatic rate test done");
    @(negedge clk_sys_in);
    ce_in = 1'b0;
    measured_valid_in = 1'b1;
    measured_rate_in = (last == 4'h0) ? 12'hFFF : 12'h000;
    reg_wr_in = 1'b1;
    reg_addr_in = 8'h06;
    reg_wdata_in = 16'h0008;
    @(negedge clk_sys_in);
    `CHK(cdr_rate_out, last)
    reg_wr_in = 1'b0;
    measured_valid_in = 1'b0;
    ce_in = 1'b1;
    reg_read(8'h06, 16'h3E01);
    reg_write(8'h06, 16'h0006);
    `CHK(auto_rate_enable_out, 1'b0)
    @(negedge clk_sys_in);
    soft_reset_in = 1'b1;
    `CHK(cdr_rate_out, 4'h3)
    @(negedge clk_sys_in);
    soft_reset_in = 1'b0;
    `CHK(auto_rate_enable_out, 1'b1)
    reg_read(8'h07, 16'h0003);
    reg_read(8'h06, 16'h3E01);
    $display("freeze and soft reset test done");
    test_done();
  end
endmodule
`default_nettype wire
